// [lcc_defines.svh]
// lcc_defines.svh: addresses, bit positions and reset values of the
// link core main control block; assumes a 32-bit APB byte address map
`ifndef LCC_DEFINES_SVH
`define LCC_DEFINES_SVH
// register byte addresses
`define LCC_ADDR_CTRL 32'h4000_0000
`define LCC_ADDR_MASK 32'h4000_000C
`define LCC_ADDR_STAT 32'h4000_0010
`define LCC_ADDR_ACK 32'h4000_0018
// control register bit positions
`define LCC_B_CORE_RST 31
`define LCC_B_TG_RST 30
`define LCC_B_REG_RST 29
`define LCC_B_SW_REQ 28
`define LCC_B_TEST_ABT 26
`define LCC_B_ADV_ABT 25
`define LCC_B_SCAN_ABT 24
`define LCC_B_MD_OVR 22
`define LCC_B_SN_OVR 21
`define LCC_B_ACK_OVR 20
`define LCC_B_ENC_OVR 19
// control register bits with no field, read as zero
`define LCC_B_RSV_HI 27
`define LCC_B_RSV_LO 23
// event bits of status and mask
`define LCC_EV_W 4
`define LCC_EV_SW 0
`define LCC_EV_TEST 1
`define LCC_EV_ADV 2
`define LCC_EV_SCAN 3
// reset values
`define LCC_OVR_RST 4'h0
`define LCC_EV_RST 4'h0
`define LCC_WORD_ZERO 32'h0000_0000
`endif

// [lcc_pkg.sv]
// lcc_pkg.sv: types of the link core main control block
// assumes lcc_defines.svh is available on the include path
package lcc_pkg;
	// radio test abort sequencer states
	typedef enum logic [2:0] {
		LCC_T_IDLE = 3'b000,
		LCC_T_TX_BYTE = 3'b001,
		LCC_T_TX_CRC = 3'b010,
		LCC_T_RX_PKT = 3'b011,
		LCC_T_RF_OFF = 3'b100
	} lcc_test_e;
	typedef logic [31:0] lcc_word_t;
endpackage

// [lcc_main_control.sv]
// lcc_main_control.sv: main control register of the link core, an
// APB slave with action bits, overrides and an interrupt status.
// assumes one clock, synchronous inputs, an APB4 master.
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/10ps
`include "lcc_defines.svh"

// Function
// - core soft reset pulses all but registers, timer
// - timer soft reset pulses timing generator only
// - register soft reset restores register reset values
// - register soft reset keeps interrupt status
// - software request raises masked software interrupt
// - action bits self clear; zero writes ignored
// - radio test abort stops running test
// - infinite tx: stop after byte, process crc
// - infinite rx: finish packet or rf off
// - advertising abort ends current advertising event
// - scan abort ends current scan window
// - more data override: single exchange per event
// - override: md from descriptor, rx md stored
// - sequence override: descriptor sn, no sn error
// - acknowledge override: descriptor nesn, no error
// - encryption override disables payload encryption, resets zero
// - per connection encryption: mic kept, plain data
module lcc_main_control (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire lcc_pkg::lcc_word_t paddr,
	input wire lcc_pkg::lcc_word_t pwdata,
	input wire logic [3:0] pstrb,
	output lcc_pkg::lcc_word_t prdata,
	output logic pready,
	output logic pslverr,
	// interrupts
	output logic irq,
	output logic link_software_irq,
	// soft resets to the core
	output logic core_soft_reset,
	output logic timing_generator_soft_reset,
	// advertising and scan
	input wire logic advertising_active,
	input wire logic scan_active,
	output logic advertising_abort,
	output logic scan_abort,
	// radio test packet controller
	input wire logic test_active,
	input wire logic test_infinite_rx,
	input wire logic byte_done,
	input wire logic access_addr_found,
	input wire logic packet_done,
	input wire logic crc_done,
	output logic pc_stop,
	output logic crc_process,
	output logic rf_off,
	// exchange control
	input wire logic desc_md,
	input wire logic desc_sn,
	input wire logic desc_nesn,
	input wire logic core_md,
	input wire logic core_sn,
	input wire logic core_nesn,
	input wire logic rx_md,
	input wire logic rx_sn_err,
	input wire logic rx_nesn_err,
	input wire logic per_connection_encrypt_enable,
	output logic tx_md,
	output logic tx_sn,
	output logic tx_nesn,
	output logic rx_md_store,
	output logic sn_error,
	output logic nesn_error,
	output logic more_exchange,
	output logic encrypt_payload,
	output logic mic_generate,
	output logic more_data_override,
	output logic sequence_number_override,
	output logic acknowledge_override,
	output logic encryption_override
);
	import lcc_pkg::*;

	// action bits pending, overrides, interrupt state
	logic act_core, act_tg, act_reg, act_sw;
	logic act_test, act_adv, act_scan;
	logic [3:0] ovr;
	logic [`LCC_EV_W-1:0] stat, mask;
	logic test_fin;
	lcc_test_e tstate, next_tstate;
	lcc_word_t wdat;
	logic setup, wr, hit_ctrl, hit_mask, hit_stat, hit_ack, mapped;

	// byte lanes gate the written bits
	function automatic lcc_word_t lane_mask(input lcc_word_t d,
		input logic [3:0] s);
		lane_mask = d & {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
	endfunction

	// control register image as read back
	function automatic lcc_word_t ctrl_image(input logic [6:0] a,
		input logic [3:0] o);
		lcc_word_t v;
		v = `LCC_WORD_ZERO;
		v[`LCC_B_CORE_RST] = a[6];
		v[`LCC_B_TG_RST] = a[5];
		v[`LCC_B_REG_RST] = a[4];
		v[`LCC_B_SW_REQ] = a[3];
		v[`LCC_B_TEST_ABT] = a[2];
		v[`LCC_B_ADV_ABT] = a[1];
		v[`LCC_B_SCAN_ABT] = a[0];
		v[`LCC_B_MD_OVR] = o[3];
		v[`LCC_B_SN_OVR] = o[2];
		v[`LCC_B_ACK_OVR] = o[1];
		v[`LCC_B_ENC_OVR] = o[0];
		ctrl_image = v;
	endfunction

	// address decode and write strobe
	assign setup = psel & ~penable;
	assign wr = psel & penable & pwrite;
	assign hit_ctrl = (paddr == `LCC_ADDR_CTRL);
	assign hit_mask = (paddr == `LCC_ADDR_MASK);
	assign hit_stat = (paddr == `LCC_ADDR_STAT);
	assign hit_ack = (paddr == `LCC_ADDR_ACK);
	assign mapped = hit_ctrl | hit_mask | hit_stat | hit_ack;
	assign wdat = lane_mask(pwdata, pstrb);
	assign pready = psel & penable;
	assign pslverr = psel & penable & ~mapped;

	// read data latched in the setup cycle
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			prdata <= `LCC_WORD_ZERO;
		end else if (setup & ~pwrite) begin
			if (hit_ctrl) begin
				prdata <= ctrl_image({act_core, act_tg, act_reg, act_sw,
					act_test, act_adv, act_scan}, ovr);
			end else if (hit_mask) begin
				prdata <= {28'h000_0000, mask};
			end else if (hit_stat) begin
				prdata <= {28'h000_0000, stat};
			end else begin
				prdata <= `LCC_WORD_ZERO;
			end
		end
	end

	// one-shot action bits: set by a one, clear after one cycle
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			act_core <= 1'b0;
			act_tg <= 1'b0;
			act_reg <= 1'b0;
			act_sw <= 1'b0;
		end else begin
			act_core <= wr & hit_ctrl & wdat[`LCC_B_CORE_RST];
			act_tg <= wr & hit_ctrl & wdat[`LCC_B_TG_RST];
			act_reg <= wr & hit_ctrl & wdat[`LCC_B_REG_RST];
			act_sw <= wr & hit_ctrl & wdat[`LCC_B_SW_REQ];
		end
	end

	// soft reset pulses to the core
	assign core_soft_reset = act_core;
	assign timing_generator_soft_reset = act_tg;

	// abort bits stay pending until the activity has ended
	always_ff @(posedge clk) begin
		if (sys_rst | act_reg) begin
			act_test <= 1'b0;
			act_adv <= 1'b0;
			act_scan <= 1'b0;
		end else begin
			if (wr & hit_ctrl & wdat[`LCC_B_TEST_ABT]) begin
				act_test <= 1'b1;
			end else if (test_fin) begin
				act_test <= 1'b0;
			end
			if (wr & hit_ctrl & wdat[`LCC_B_ADV_ABT]) begin
				act_adv <= 1'b1;
			end else if (~advertising_active) begin
				act_adv <= 1'b0;
			end
			if (wr & hit_ctrl & wdat[`LCC_B_SCAN_ABT]) begin
				act_scan <= 1'b1;
			end else if (~scan_active) begin
				act_scan <= 1'b0;
			end
		end
	end

	// abort requests held toward the event engines
	assign advertising_abort = act_adv;
	assign scan_abort = act_scan;

	// override bits and interrupt mask, cleared by register reset
	always_ff @(posedge clk) begin
		if (sys_rst | act_reg) begin
			ovr <= `LCC_OVR_RST;
			mask <= `LCC_EV_RST;
		end else begin
			if (wr & hit_ctrl) begin
				ovr <= {wdat[`LCC_B_MD_OVR], wdat[`LCC_B_SN_OVR],
					wdat[`LCC_B_ACK_OVR], wdat[`LCC_B_ENC_OVR]};
			end
			if (wr & hit_mask) begin
				mask <= wdat[`LCC_EV_W-1:0];
			end
		end
	end

	// sticky status: events win over clears, survive register reset
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			stat <= `LCC_EV_RST;
		end else begin
			stat <= (stat & ~(((wr & (hit_stat | hit_ack)) ?
				wdat[`LCC_EV_W-1:0] : `LCC_EV_RST)))
				| {~scan_active & act_scan, ~advertising_active & act_adv,
				test_fin, act_sw};
		end
	end

	// interrupt outputs
	assign irq = |(stat & mask);
	assign link_software_irq = stat[`LCC_EV_SW] & mask[`LCC_EV_SW];

	// radio test abort sequencer, next state
	always_comb begin
		next_tstate = tstate;
		case (tstate)
			LCC_T_IDLE: begin
				if (act_test & test_active) begin
					if (~test_infinite_rx) begin
						next_tstate = LCC_T_TX_BYTE;
					end else if (access_addr_found) begin
						next_tstate = LCC_T_RX_PKT;
					end else begin
						next_tstate = LCC_T_RF_OFF;
					end
				end
			end
			LCC_T_TX_BYTE: begin
				if (byte_done) begin
					next_tstate = LCC_T_TX_CRC;
				end
			end
			LCC_T_TX_CRC: begin
				if (crc_done) begin
					next_tstate = LCC_T_IDLE;
				end
			end
			LCC_T_RX_PKT: begin
				if (packet_done) begin
					next_tstate = LCC_T_IDLE;
				end
			end
			LCC_T_RF_OFF: begin
				next_tstate = LCC_T_IDLE;
			end
			default: begin
				next_tstate = LCC_T_IDLE;
			end
		endcase
	end

	// sequencer state register
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tstate <= LCC_T_IDLE;
		end else begin
			tstate <= next_tstate;
		end
	end

	// abort finished: back to idle, or nothing was running
	assign test_fin = act_test & (((tstate != LCC_T_IDLE) &
		(next_tstate == LCC_T_IDLE)) |
		((tstate == LCC_T_IDLE) & ~test_active));

	// packet controller stop, crc and rf off strobes
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pc_stop <= 1'b0;
			crc_process <= 1'b0;
			rf_off <= 1'b0;
		end else begin
			pc_stop <= ((tstate == LCC_T_TX_BYTE) & byte_done) |
				((tstate == LCC_T_RX_PKT) & packet_done) |
				(next_tstate == LCC_T_RF_OFF);
			crc_process <= (next_tstate == LCC_T_TX_CRC);
			rf_off <= (next_tstate == LCC_T_RF_OFF);
		end
	end

	// override levels toward the packet controller
	assign more_data_override = ovr[3];
	assign sequence_number_override = ovr[2];
	assign acknowledge_override = ovr[1];
	assign encryption_override = ovr[0];

	// exchange fields chosen per override, registered
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tx_md <= 1'b0;
			tx_sn <= 1'b0;
			tx_nesn <= 1'b0;
			rx_md_store <= 1'b0;
			sn_error <= 1'b0;
			nesn_error <= 1'b0;
			more_exchange <= 1'b0;
			encrypt_payload <= 1'b0;
			mic_generate <= 1'b0;
		end else begin
			tx_md <= ovr[3] ? desc_md : core_md;
			rx_md_store <= rx_md;
			more_exchange <= ~ovr[3] & (rx_md | core_md);
			tx_sn <= ovr[2] ? desc_sn : core_sn;
			sn_error <= ~ovr[2] & rx_sn_err;
			tx_nesn <= ovr[1] ? desc_nesn : core_nesn;
			nesn_error <= ~ovr[1] & rx_nesn_err;
			encrypt_payload <= per_connection_encrypt_enable &
				~ovr[0];
			mic_generate <= per_connection_encrypt_enable;
		end
	end

	// checks of the documented behaviour
	chk_core_rst_pulse: assert property (@(posedge clk) disable iff (sys_rst)
		wr & hit_ctrl & wdat[`LCC_B_CORE_RST] |=> core_soft_reset ##1
		~core_soft_reset | (wr & hit_ctrl & wdat[`LCC_B_CORE_RST]))
		else $error("core soft reset pulse wrong");
	chk_tg_rst_only: assert property (@(posedge clk) disable iff (sys_rst)
		wr & hit_ctrl & wdat[`LCC_B_TG_RST] &
		~wdat[`LCC_B_CORE_RST] |=> timing_generator_soft_reset &
		~core_soft_reset)
		else $error("timer soft reset not isolated");
	chk_reg_rst_clear: assert property (@(posedge clk) disable iff (sys_rst)
		act_reg |=> (ovr == `LCC_OVR_RST) && (mask == `LCC_EV_RST))
		else $error("register reset left values");
	chk_stat_survives: assert property (@(posedge clk) disable iff (sys_rst)
		act_reg & ~(wr & (hit_stat | hit_ack)) |=>
		((stat & $past(stat)) == $past(stat)))
		else $error("status lost on register reset");
	chk_sw_irq_raise: assert property (@(posedge clk) disable iff (sys_rst)
		act_sw & mask[`LCC_EV_SW] & ~act_reg |=> link_software_irq & irq)
		else $error("software irq not raised");
	chk_action_clears: assert property (@(posedge clk) disable iff (sys_rst)
		act_sw & ~(wr & hit_ctrl & wdat[`LCC_B_SW_REQ]) |=> ~act_sw)
		else $error("action bit did not clear");
	chk_tx_byte_stop: assert property (@(posedge clk) disable iff (sys_rst)
		(tstate == LCC_T_TX_BYTE) & byte_done |=> pc_stop & crc_process)
		else $error("tx abort missed byte stop");
	chk_rx_rf_off: assert property (@(posedge clk) disable iff (sys_rst)
		(tstate == LCC_T_IDLE) & act_test & test_active &
		test_infinite_rx & ~access_addr_found |=> rf_off & pc_stop ##1
		~rf_off)
		else $error("rx abort did not switch rf off");
	chk_adv_abort_out: assert property (@(posedge clk) disable iff (sys_rst)
		wr & hit_ctrl & wdat[`LCC_B_ADV_ABT] & ~act_reg |=>
		advertising_abort)
		else $error("advertising abort not issued");
	chk_md_single: assert property (@(posedge clk) disable iff (sys_rst)
		ovr[3] |=> ~more_exchange)
		else $error("extra exchange under md override");
	chk_sn_no_error: assert property (@(posedge clk) disable iff (sys_rst)
		ovr[2] & rx_sn_err |=> ~sn_error & (tx_sn == $past(desc_sn)))
		else $error("sn override not honoured");
	chk_enc_plain: assert property (@(posedge clk) disable iff (sys_rst)
		ovr[0] & per_connection_encrypt_enable |=>
		mic_generate & ~encrypt_payload)
		else $error("encryption override wrong");
	chk_reserved_zero: assert property (@(posedge clk) disable iff (sys_rst)
		$past(setup & ~pwrite & hit_ctrl) & ~setup |->
		~prdata[`LCC_B_RSV_HI] & ~prdata[`LCC_B_RSV_LO])
		else $error("reserved bits not zero");

endmodule // lcc_main_control

// [test_lcc_main_control.sv]
// test_lcc_main_control.sv: self-checking bench of the link core main
// control block; assumes lcc_defines.svh and lcc_pkg are compiled first
`timescale 1ns/10ps
`include "lcc_defines.svh"
module test_lcc_main_control;
	import lcc_pkg::*;
	logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, irq, err;
	lcc_word_t paddr, pwdata, prdata, rd;
	logic [3:0] pstrb;
	logic link_software_irq, core_soft_reset, timing_generator_soft_reset;
	logic advertising_active, scan_active, advertising_abort, scan_abort;
	logic test_active, test_infinite_rx, byte_done, access_addr_found;
	logic packet_done, crc_done, pc_stop, crc_process, rf_off;
	logic desc_md, desc_sn, desc_nesn, core_md, core_sn, core_nesn, rx_md;
	logic rx_sn_err, rx_nesn_err, per_connection_encrypt_enable;
	logic tx_md, tx_sn, tx_nesn, rx_md_store, sn_error, nesn_error;
	logic more_exchange, encrypt_payload, mic_generate, more_data_override;
	logic sequence_number_override, acknowledge_override;
	logic encryption_override;
	int num_errors, n_tests, cyc, n_stop, n_off;

	// device under test
	lcc_main_control i_lcc_main_control (.clk, .sys_rst, .psel, .penable,
		.pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .irq,
		.link_software_irq, .core_soft_reset, .timing_generator_soft_reset,
		.advertising_active, .scan_active, .advertising_abort, .scan_abort,
		.test_active, .test_infinite_rx, .byte_done, .access_addr_found,
		.packet_done, .crc_done, .pc_stop, .crc_process, .rf_off, .desc_md,
		.desc_sn, .desc_nesn, .core_md, .core_sn, .core_nesn, .rx_md,
		.rx_sn_err, .rx_nesn_err, .per_connection_encrypt_enable, .tx_md,
		.tx_sn, .tx_nesn, .rx_md_store, .sn_error, .nesn_error,
		.more_exchange, .encrypt_payload, .mic_generate,
		.more_data_override, .sequence_number_override,
		.acknowledge_override, .encryption_override);

	// 250 MHz clock
	initial begin
		clk = 0;
		forever #2 clk = ~clk;
	end

	// pulse counters and hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (pc_stop === 1'b1) n_stop <= n_stop + 1;
		if (rf_off === 1'b1) n_off <= n_off + 1;
		if (cyc == 4000) begin
			num_errors = num_errors + 1;
			complete_run();
		end
	end

	task automatic chk(input string nm, input lcc_word_t e, input lcc_word_t g);
		n_tests++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask

	// one apb transfer; returns just after the edge that completes it
	task automatic apb(input logic wr, input lcc_word_t a, input lcc_word_t d);
		@(posedge clk);
		psel <= 1;
		penable <= 0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		chk("pready", 1, pready);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask

	task automatic rdchk(input string nm, input lcc_word_t a, input lcc_word_t e);
		apb(0, a, 0);
		chk(nm, e, rd);
	endtask

	task automatic t_reset();
		rdchk("ctrl", `LCC_ADDR_CTRL, 0);
		rdchk("mask", `LCC_ADDR_MASK, 0);
		rdchk("stat", `LCC_ADDR_STAT, 0);
		apb(1, 32'h4000_0004, 32'hFFFF_FFFF);
		chk("wr err", 1, err);
		rdchk("unmapped", 32'h4000_0004, 0);
		chk("rd err", 1, err);
		$display("test reset done");
	endtask

	// bit 31 and 30 give one pulse each, zero does nothing
	task automatic t_pulse(input int b);
		apb(1, `LCC_ADDR_CTRL, 32'h1 << b);
		#1;
		chk("core rst", b == 31, core_soft_reset);
		chk("tg rst", b == 30, timing_generator_soft_reset);
		@(posedge clk);
		#1;
		chk("core rst off", 0, core_soft_reset);
		chk("tg rst off", 0, timing_generator_soft_reset);
		rdchk("ctrl clr", `LCC_ADDR_CTRL, 0);
		$display("test pulse %0d done", b);
	endtask

	task automatic t_swirq(input logic m);
		apb(1, `LCC_ADDR_MASK, {31'h0, m});
		apb(1, `LCC_ADDR_CTRL, 32'h1000_0000);
		repeat (4) @(posedge clk);
		#1;
		chk("sw irq", m, link_software_irq);
		chk("irq", m, irq);
		rdchk("stat sw", `LCC_ADDR_STAT, 1);
		apb(1, m ? `LCC_ADDR_ACK : `LCC_ADDR_STAT, 1);
		#1;
		chk("irq clr", 0, irq);
		rdchk("stat clr", `LCC_ADDR_STAT, 0);
		$display("test swirq %0d done", m);
	endtask

	task automatic t_ovr(input logic on);
		apb(1, `LCC_ADDR_CTRL, on ? 32'h08F8_0000 : 0);
		rdchk("ctrl ovr", `LCC_ADDR_CTRL, on ? 32'h0078_0000 : 0);
		repeat (2) @(posedge clk);
		#1;
		chk("md ovr", on, more_data_override);
		chk("sn ovr", on, sequence_number_override);
		chk("ack ovr", on, acknowledge_override);
		chk("enc ovr", on, encryption_override);
		chk("tx md", on, tx_md);
		chk("tx sn", on, tx_sn);
		chk("tx nesn", on, tx_nesn);
		chk("sn err", !on, sn_error);
		chk("nesn err", !on, nesn_error);
		chk("enc pay", !on, encrypt_payload);
		chk("mic", 1, mic_generate);
		chk("md store", 1, rx_md_store);
		chk("more xchg", !on, more_exchange);
		// lane 2 strobe off: override bits arrive as zero
		@(posedge clk);
		pstrb <= 4'hB;
		apb(1, `LCC_ADDR_CTRL, 32'h0078_0000);
		pstrb <= 4'hF;
		rdchk("ctrl strb", `LCC_ADDR_CTRL, 0);
		$display("test override %0d done", on);
	endtask

	task automatic t_regrst();
		apb(1, `LCC_ADDR_MASK, 1);
		apb(1, `LCC_ADDR_CTRL, 32'h1000_0000);
		apb(1, `LCC_ADDR_CTRL, 32'h2078_0000);
		repeat (3) @(posedge clk);
		rdchk("ctrl rr", `LCC_ADDR_CTRL, 0);
		rdchk("mask rr", `LCC_ADDR_MASK, 0);
		rdchk("stat rr", `LCC_ADDR_STAT, 1);
		apb(1, `LCC_ADDR_ACK, 1);
		rdchk("stat ack", `LCC_ADDR_STAT, 0);
		$display("test regrst done");
	endtask

	task automatic t_abort(input logic sc);
		if (sc) scan_active <= 1;
		else advertising_active <= 1;
		apb(1, `LCC_ADDR_CTRL, sc ? 32'h0100_0000 : 32'h0200_0000);
		repeat (2) @(posedge clk);
		#1;
		chk("abort", 1, sc ? scan_abort : advertising_abort);
		rdchk("ctrl ab", `LCC_ADDR_CTRL, sc ? 32'h0100_0000 : 32'h0200_0000);
		if (sc) scan_active <= 0;
		else advertising_active <= 0;
		repeat (3) @(posedge clk);
		#1;
		chk("abort off", 0, sc ? scan_abort : advertising_abort);
		rdchk("stat ab", `LCC_ADDR_STAT, sc ? 8 : 4);
		apb(1, `LCC_ADDR_STAT, 32'hF);
		$display("test abort %0d done", sc);
	endtask

	// infinite tx: stop after byte, then crc step
	task automatic t_test_tx();
		test_active <= 1;
		test_infinite_rx <= 0;
		apb(1, `LCC_ADDR_CTRL, 32'h0400_0000);
		repeat (3) @(posedge clk);
		#1;
		chk("no stop", 0, pc_stop);
		@(posedge clk);
		byte_done <= 1;
		@(posedge clk);
		byte_done <= 0;
		#1;
		chk("stop", 1, pc_stop);
		chk("crc", 1, crc_process);
		@(posedge clk);
		crc_done <= 1;
		@(posedge clk);
		crc_done <= 0;
		#1;
		chk("crc off", 0, crc_process);
		rdchk("stat tx", `LCC_ADDR_STAT, 2);
		apb(1, `LCC_ADDR_ACK, 2);
		$display("test rf tx done");
	endtask

	// infinite rx: packet end when address seen, else rf off
	task automatic t_test_rx(input logic aa);
		test_infinite_rx <= 1;
		access_addr_found <= aa;
		#1;
		n_stop = 0;
		n_off = 0;
		apb(1, `LCC_ADDR_CTRL, 32'h0400_0000);
		repeat (4) @(posedge clk);
		chk("rx stop early", !aa, n_stop);
		packet_done <= 1;
		@(posedge clk);
		packet_done <= 0;
		repeat (3) @(posedge clk);
		chk("rx stops", 1, n_stop);
		chk("rf off", !aa, n_off);
		rdchk("stat rx", `LCC_ADDR_STAT, 2);
		apb(1, `LCC_ADDR_ACK, 2);
		$display("test rf rx %0d done", aa);
	endtask

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	// main sequence
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = 0;
		{advertising_active, scan_active, test_active, test_infinite_rx} = 0;
		{byte_done, access_addr_found, packet_done, crc_done} = 0;
		{core_md, core_sn, core_nesn, cyc, n_stop, n_off} = 0;
		{desc_md, desc_sn, desc_nesn, rx_md, rx_sn_err, rx_nesn_err} = '1;
		per_connection_encrypt_enable = 1;
		pstrb = 4'hF;
		sys_rst = 1;
		repeat (4) @(posedge clk);
		sys_rst <= 0;
		t_reset();
		t_pulse(31);
		t_pulse(30);
		t_pulse(0);
		t_swirq(1);
		t_swirq(0);
		t_ovr(1);
		t_ovr(0);
		t_regrst();
		t_abort(0);
		t_abort(1);
		t_test_tx();
		t_test_rx(0);
		t_test_rx(1);
		complete_run();
	end
endmodule // test_lcc_main_control
